// ### rtl/psp_pkg.sv
/*
 * Package for the parallel slave port: register offsets, field positions,
 * reset values, state encoding and the packed carriers of the block.
 * Assumes a single 100 MHz clock domain and a plain strobed register port.
 */
package psp_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // Register offsets on the local register port.
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_PORT_D_PINS = 4'h1;
    localparam logic [3:0] OFS_PORT_D_LATCH = 4'h2;
    localparam logic [3:0] OFS_PORT_D_DIR = 4'h3;
    localparam logic [3:0] OFS_PORT_E_PINS = 4'h4;
    localparam logic [3:0] OFS_PORT_E_LATCH = 4'h5;
    localparam logic [3:0] OFS_PORT_E_DIR = 4'h6;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h7;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h8;

    // Control register fields.
    localparam int unsigned BIT_INPUT_FULL = 7;
    localparam int unsigned BIT_OUTPUT_FULL = 6;
    localparam int unsigned BIT_INPUT_OVERFLOW = 5;
    localparam int unsigned BIT_MODE = 4;

    // Port E strobe pin positions.
    localparam int unsigned PIN_RD = 0;
    localparam int unsigned PIN_WR = 1;
    localparam int unsigned PIN_CS = 2;

    // Interrupt status bits.
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_SLAVE_PORT = 0;
    localparam int unsigned IRQ_WRITE_DONE = 1;
    localparam int unsigned IRQ_READ_DONE = 2;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [2:0] STROBE_IDLE = 3'h7;
    localparam logic [2:0] STROBE_DIR_MASK = 3'h7;

    typedef enum logic [2:0] {
        PSP_IDLE = 3'b001,
        PSP_WRITE = 3'b010,
        PSP_READ = 3'b100
    } psp_state_t;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } psp_strobe_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } psp_req_t;

    typedef struct packed {
        psp_strobe_t sync1;
        psp_strobe_t sync2;
        psp_state_t state;
        logic mode;
        logic input_full_flag;
        logic output_full_flag;
        logic input_overflow_flag;
        logic slave_irq;
        logic [7:0] latch_d;
        logic [7:0] dir_d;
        logic [7:0] latch_e;
        logic [7:0] dir_e;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [7:0] rdata;
    } psp_state_s_t;

endpackage

// ### rtl/psp_top.sv
/*
 * Parallel slave port on port D with its strobes on port E, plus the
 * general purpose I/O function of both ports and a small interrupt unit.
 * Assumes the external strobes are asynchronous, the register master keeps
 * one-cycle strobes, and single-chip mode is signalled on a level input.
 */
// Summary of operation
// - Mode bit set turns eight port D pins into a parallel data port.
// - External party reads and writes the port D latch asynchronously.
// - Mode bit assigns E0 to read, E1 to write, E2 to chip select.
// - Port E direction bits 2 to 0 must be inputs for strobes to work.
// - Write runs while select and write strobe are low, ends on either high.
// - End of write sets the slave port interrupt and input full flags.
// - Port D latch is one byte: writes store it, reads present it.
// - Read starts on select and read strobe low; latch is driven out.
// - CPU write during a read drives out at once, output full stays clear.
// - Read end releases port D pins and sets the interrupt flag.
// - Software waits for interrupt flag then polls input and output full.
// - Input full reads one while an external word waits for the CPU.
// - Output full reads one until the external party reads the word.
// - Write while input full sets overflow; only software clears it.
// - Mode bit one is slave port, zero is I/O; low four bits read zero.
// - Slave port works only in single-chip mode, not external bus mode.
module psp_top #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Operating mode
    input wire logic single_chip_mode_i,
    // Port D pins
    input wire logic [7:0] port_d_pins_i,
    output logic [7:0] port_d_pins_o,
    output logic [7:0] port_d_pins_oe_o,
    // Port E pins
    input wire logic [7:0] port_e_pins_i,
    output logic [7:0] port_e_pins_o,
    output logic [7:0] port_e_pins_oe_o,
    // Interrupt
    output logic slave_port_irq_flag_o,
    output logic irq_o
);

    initial
    begin
        if (WIDTH != psp_pkg::DATA_W)
        begin
            $error("psp_top serves an 8-bit data port only.");
        end
    end

    psp_pkg::psp_state_s_t s_q;
    psp_pkg::psp_state_s_t s_d;
    psp_pkg::psp_req_t req;
    psp_pkg::psp_strobe_t pins;
    logic active;
    logic strobes_in;
    logic sel_wr;
    logic sel_rd;
    logic cpu_wr_d;
    logic cpu_rd_d;
    logic [7:0] rd_mux;

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
                   wr: reg_wr_i, rd: reg_rd_i};
    assign pins = '{cs_n: port_e_pins_i[psp_pkg::PIN_CS],
                    wr_n: port_e_pins_i[psp_pkg::PIN_WR],
                    rd_n: port_e_pins_i[psp_pkg::PIN_RD]};

    // Strobes only count when they really are inputs.
    assign strobes_in = &(s_q.dir_e[2:0] & psp_pkg::STROBE_DIR_MASK);
    assign active = s_q.mode && single_chip_mode_i && strobes_in;
    assign sel_wr = !s_q.sync2.cs_n && !s_q.sync2.wr_n;
    assign sel_rd = !s_q.sync2.cs_n && !s_q.sync2.rd_n;
    assign cpu_wr_d = req.wr && (req.addr == psp_pkg::OFS_PORT_D_PINS ||
                                 req.addr == psp_pkg::OFS_PORT_D_LATCH);
    assign cpu_rd_d = req.rd && req.addr == psp_pkg::OFS_PORT_D_PINS;

    always_comb
    begin
        rd_mux = psp_pkg::RST_BYTE;
        case (req.addr)
            psp_pkg::OFS_CONTROL:
            begin
                rd_mux[psp_pkg::BIT_INPUT_FULL] = s_q.input_full_flag;
                rd_mux[psp_pkg::BIT_OUTPUT_FULL] = s_q.output_full_flag;
                rd_mux[psp_pkg::BIT_INPUT_OVERFLOW] = s_q.input_overflow_flag;
                rd_mux[psp_pkg::BIT_MODE] = s_q.mode;
            end
            // In slave mode the CPU reads the byte written from outside.
            psp_pkg::OFS_PORT_D_PINS:
                rd_mux = s_q.mode ? s_q.latch_d : port_d_pins_i;
            psp_pkg::OFS_PORT_D_LATCH: rd_mux = s_q.latch_d;
            psp_pkg::OFS_PORT_D_DIR: rd_mux = s_q.dir_d;
            psp_pkg::OFS_PORT_E_PINS: rd_mux = port_e_pins_i;
            psp_pkg::OFS_PORT_E_LATCH: rd_mux = s_q.latch_e;
            psp_pkg::OFS_PORT_E_DIR: rd_mux = s_q.dir_e;
            psp_pkg::OFS_IRQ_STATUS:
                rd_mux[psp_pkg::IRQ_W-1:0] = s_q.irq_stat;
            psp_pkg::OFS_IRQ_MASK:
                rd_mux[psp_pkg::IRQ_W-1:0] = s_q.irq_mask;
            default: rd_mux = psp_pkg::RST_BYTE;
        endcase
    end

    always_comb
    begin
        logic wr_end;
        logic rd_end;
        logic [2:0] ev;
        wr_end = 1'b0;
        rd_end = 1'b0;
        ev = 3'h0;
        s_d = s_q;
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.rdata = req.rd ? rd_mux : psp_pkg::RST_BYTE;

        // CPU register writes.
        if (req.wr)
        begin
            case (req.addr)
                psp_pkg::OFS_CONTROL:
                begin
                    s_d.mode = req.wdata[psp_pkg::BIT_MODE];
                    // Software may only clear the overflow flag.
                    if (!req.wdata[psp_pkg::BIT_INPUT_OVERFLOW])
                    begin
                        s_d.input_overflow_flag = 1'b0;
                    end
                end
                psp_pkg::OFS_PORT_D_PINS,
                psp_pkg::OFS_PORT_D_LATCH: s_d.latch_d = req.wdata;
                psp_pkg::OFS_PORT_D_DIR: s_d.dir_d = req.wdata;
                psp_pkg::OFS_PORT_E_PINS,
                psp_pkg::OFS_PORT_E_LATCH: s_d.latch_e = req.wdata;
                psp_pkg::OFS_PORT_E_DIR: s_d.dir_e = req.wdata;
                psp_pkg::OFS_IRQ_MASK:
                    s_d.irq_mask = req.wdata[psp_pkg::IRQ_W-1:0];
                default: s_d.irq_mask = s_q.irq_mask;
            endcase
        end

        if (s_q.mode)
        begin
            if (cpu_rd_d)
            begin
                s_d.input_full_flag = 1'b0;
            end
            // During a read the new byte goes straight out, so it is
            // already consumed and the output full flag stays clear.
            if (cpu_wr_d && s_q.state != psp_pkg::PSP_READ)
            begin
                s_d.output_full_flag = 1'b1;
            end
        end

        case (s_q.state)
            psp_pkg::PSP_IDLE:
            begin
                if (active && sel_wr)
                begin
                    s_d.state = psp_pkg::PSP_WRITE;
                end
                else if (active && sel_rd)
                begin
                    s_d.state = psp_pkg::PSP_READ;
                    s_d.output_full_flag = 1'b0;
                end
            end
            psp_pkg::PSP_WRITE:
            begin
                // The bus byte is tracked until the strobe rises.
                s_d.latch_d = port_d_pins_i;
                if (!sel_wr || !active)
                begin
                    s_d.state = psp_pkg::PSP_IDLE;
                    wr_end = 1'b1;
                end
            end
            psp_pkg::PSP_READ:
            begin
                if (!sel_rd || !active)
                begin
                    s_d.state = psp_pkg::PSP_IDLE;
                    rd_end = 1'b1;
                end
            end
            default: s_d.state = psp_pkg::PSP_IDLE;
        endcase

        // Hardware sets win over the software clear in the same cycle.
        if (wr_end)
        begin
            if (s_q.input_full_flag && !(cpu_rd_d && s_q.mode))
            begin
                s_d.input_overflow_flag = 1'b1;
            end
            s_d.input_full_flag = 1'b1;
        end
        if (wr_end || rd_end)
        begin
            s_d.slave_irq = 1'b1;
        end

        ev[psp_pkg::IRQ_SLAVE_PORT] = wr_end || rd_end;
        ev[psp_pkg::IRQ_WRITE_DONE] = wr_end;
        ev[psp_pkg::IRQ_READ_DONE] = rd_end;
        if (req.rd && req.addr == psp_pkg::OFS_IRQ_STATUS)
        begin
            s_d.irq_stat = ev;
            s_d.slave_irq = wr_end || rd_end;
        end
        else
        begin
            s_d.irq_stat = s_q.irq_stat | ev;
        end

        if (!s_q.mode)
        begin
            s_d.state = psp_pkg::PSP_IDLE;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            s_q <= '{sync1: psp_pkg::STROBE_IDLE,
                     sync2: psp_pkg::STROBE_IDLE,
                     state: psp_pkg::PSP_IDLE,
                     mode: 1'b0, input_full_flag: 1'b0, output_full_flag: 1'b0, input_overflow_flag: 1'b0,
                     slave_irq: 1'b0,
                     latch_d: psp_pkg::RST_BYTE,
                     dir_d: psp_pkg::RST_DIR,
                     latch_e: psp_pkg::RST_BYTE,
                     dir_e: psp_pkg::RST_DIR,
                     irq_stat: 3'h0, irq_mask: 3'h0,
                     rdata: psp_pkg::RST_BYTE};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    always_comb
    begin
        port_d_pins_o = s_q.latch_d;
        port_d_pins_oe_o = ~s_q.dir_d;
        port_e_pins_o = s_q.latch_e;
        port_e_pins_oe_o = ~s_q.dir_e;
        if (s_q.mode)
        begin
            // Port D is only driven during a read cycle.
            port_d_pins_oe_o = (s_q.state == psp_pkg::PSP_READ) ?
                               8'hFF : 8'h00;
            port_e_pins_oe_o[2:0] = 3'h0;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    assign slave_port_irq_flag_o = s_q.slave_irq;
    assign irq_o = |(s_q.irq_stat & s_q.irq_mask);

endmodule

// ### tb/psp_host_model.sv
/* External processor model that drives the slave port strobes and data.
   Assumes the bench calls its tasks just after a rising clock edge. */
module psp_host_model (
    // Clock
    input wire logic clk_i,
    // Device pin drivers
    input wire logic [7:0] dev_d_i,
    input wire logic [7:0] dev_d_oe_i,
    input wire logic [7:0] dev_e_i,
    input wire logic [7:0] dev_e_oe_i,
    // Resolved pin levels
    output logic [7:0] d_pins_o,
    output logic [7:0] e_pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv_q = 8'hFF;
    logic [2:0] strb_q = 3'h7;
    // Released data lines show the inverse so a stale byte never matches.
    assign d_pins_o = (dev_d_oe_i & dev_d_i) | (~dev_d_oe_i & drv_q);
    assign e_pins_o = (dev_e_oe_i & dev_e_i) | (~dev_e_oe_i & {5'h1F, strb_q});
    task automatic ext_write(input logic [7:0] data);
        drv_q <= data;
        strb_q <= 3'h1;
        repeat (5) @(posedge clk_i);
        strb_q <= 3'h7;
        repeat (4) @(posedge clk_i);
        drv_q <= ~data;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic read_start();
        strb_q <= 3'h2;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic read_end(output logic [7:0] data);
        data = d_pins_o;
        strb_q <= 3'h7;
        repeat (5) @(posedge clk_i);
    endtask
endmodule

// ### tb/psp_monitor.sv
/* Checker for the slave port top level, bound to every instance.
   Assumes one clock and a synchronous active low reset. */
module psp_monitor #(
    parameter int unsigned WIDTH = 8
) (
    // Watched ports
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] port_d_pins_o,
    input wire logic [7:0] port_d_pins_oe_o,
    input wire logic [7:0] port_e_pins_i,
    input wire logic slave_port_irq_flag_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read slot");
    a_ctrl_low_zero: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) == psp_pkg::OFS_CONTROL
        |-> reg_rdata_o[3:0] == 4'h0) else $error("control low bits not zero");
    a_flag_clear: assert property ($fell(slave_port_irq_flag_o) |->
        $past(reg_rd_i) && $past(reg_addr_i) == psp_pkg::OFS_IRQ_STATUS)
        else $error("irq flag cleared without status read");
    a_flag_cause: assert property ($rose(slave_port_irq_flag_o) |->
        $past(port_e_pins_i[2] || (port_e_pins_i[1] && port_e_pins_i[0]), 2))
        else $error("irq flag set while a cycle still runs");
    a_irq_rise: assert property ($rose(irq_o) |-> slave_port_irq_flag_o ||
        $past(reg_wr_i) || $past(reg_wr_i, 2)) else $error("irq without cause");
    a_drive_start: assert property (
        $rose(&port_d_pins_oe_o) && !$past(reg_wr_i) && !$past(reg_wr_i, 2)
        |-> $past(!port_e_pins_i[0] && !port_e_pins_i[2], 2))
        else $error("port driven without read strobes");
    a_drive_release: assert property (
        $rose(port_e_pins_i[0]) && port_d_pins_oe_o == 8'hFF
        |-> ##[1:5] port_d_pins_oe_o == 8'h00) else $error("port not released");
    a_latch_cause: assert property ($changed(port_d_pins_o) |->
        $past(reg_wr_i) || !$past(port_e_pins_i[1], 2) ||
        !$past(port_e_pins_i[1], 4) || !$past(port_e_pins_i[1], 6))
        else $error("latch changed without a write");
    c_flag: cover property ($rose(slave_port_irq_flag_o));
    c_drive: cover property ($rose(port_d_pins_oe_o[0]));
    c_irq: cover property ($rose(irq_o));
endmodule
bind psp_top psp_monitor #(.WIDTH(WIDTH)) i_psp_monitor (.clk_i, .nrst_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .port_d_pins_o,
    .port_d_pins_oe_o, .port_e_pins_i, .slave_port_irq_flag_o, .irq_o);

// ### tb/testbench.sv
/* Register level tests of the slave port with an external processor model.
   Assumes fixed design latencies, so every wait is a fixed cycle count. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, nrst_i, reg_wr_i, reg_rd_i, single_chip_mode_i;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, port_d_pins_i, port_d_pins_o;
    logic [7:0] port_d_pins_oe_o, port_e_pins_i, port_e_pins_o;
    logic [7:0] port_e_pins_oe_o, v;
    logic slave_port_irq_flag_o, irq_o;
    int error_cnt = 0;
    int checks = 0;
    psp_top #(.WIDTH(8)) i_psp_top (.clk_i, .nrst_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .single_chip_mode_i,
        .port_d_pins_i, .port_d_pins_o, .port_d_pins_oe_o, .port_e_pins_i,
        .port_e_pins_o, .port_e_pins_oe_o, .slave_port_irq_flag_o, .irq_o);
    psp_host_model i_psp_host_model (.clk_i, .dev_d_i(port_d_pins_o),
        .dev_d_oe_i(port_d_pins_oe_o), .dev_e_i(port_e_pins_o),
        .dev_e_oe_i(port_e_pins_oe_o), .d_pins_o(port_d_pins_i),
        .e_pins_o(port_e_pins_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
        @(posedge clk_i);
    endtask
    task automatic print_verdict();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        {nrst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        single_chip_mode_i = 1'b1;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        rchk(psp_pkg::OFS_CONTROL, 8'h00);
        rchk(psp_pkg::OFS_PORT_D_DIR, 8'hFF);
        rchk(4'hF, 8'h00);
        wr(psp_pkg::OFS_PORT_D_DIR, 8'h0F);
        chk(port_d_pins_oe_o, 8'hF0);
        wr(psp_pkg::OFS_PORT_D_DIR, 8'hFF);
        wr(psp_pkg::OFS_PORT_E_LATCH, 8'hA5);
        chk(port_e_pins_o, 8'hA5);
        rchk(psp_pkg::OFS_PORT_E_LATCH, 8'hA5);
        wr(psp_pkg::OFS_CONTROL, 8'h1F);
        rchk(psp_pkg::OFS_CONTROL, 8'h10);
        $display("test reset and io done");
        i_psp_host_model.ext_write(8'h3C);
        chk({7'h00, slave_port_irq_flag_o}, 8'h01);
        chk({7'h00, irq_o}, 8'h00);
        wr(psp_pkg::OFS_IRQ_MASK, 8'h07);
        chk({7'h00, irq_o}, 8'h01);
        rchk(psp_pkg::OFS_IRQ_MASK, 8'h07);
        rchk(psp_pkg::OFS_CONTROL, 8'h90);
        rchk(psp_pkg::OFS_IRQ_STATUS, 8'h03);
        chk({7'h00, irq_o, slave_port_irq_flag_o}, 8'h00);
        i_psp_host_model.ext_write(8'h5A);
        rchk(psp_pkg::OFS_CONTROL, 8'hB0);
        rchk(psp_pkg::OFS_PORT_D_PINS, 8'h5A);
        rchk(psp_pkg::OFS_CONTROL, 8'h30);
        wr(psp_pkg::OFS_CONTROL, 8'h10);
        rchk(psp_pkg::OFS_CONTROL, 8'h10);
        rchk(psp_pkg::OFS_IRQ_STATUS, 8'h03);
        $display("test external write done");
        wr(psp_pkg::OFS_PORT_D_LATCH, 8'hC3);
        rchk(psp_pkg::OFS_CONTROL, 8'h50);
        i_psp_host_model.read_start();
        chk(port_d_pins_oe_o, 8'hFF);
        rchk(psp_pkg::OFS_CONTROL, 8'h10);
        i_psp_host_model.read_end(v);
        chk(v, 8'hC3);
        chk(port_d_pins_oe_o, 8'h00);
        rchk(psp_pkg::OFS_IRQ_STATUS, 8'h05);
        i_psp_host_model.read_start();
        wr(psp_pkg::OFS_PORT_D_LATCH, 8'h77);
        rchk(psp_pkg::OFS_CONTROL, 8'h10);
        i_psp_host_model.read_end(v);
        chk(v, 8'h77);
        rchk(psp_pkg::OFS_IRQ_STATUS, 8'h05);
        $display("test external read done");
        single_chip_mode_i <= 1'b0;
        i_psp_host_model.ext_write(8'h11);
        rchk(psp_pkg::OFS_CONTROL, 8'h10);
        chk({7'h00, slave_port_irq_flag_o}, 8'h00);
        single_chip_mode_i <= 1'b1;
        wr(psp_pkg::OFS_PORT_E_DIR, 8'hFB);
        i_psp_host_model.ext_write(8'h22);
        rchk(psp_pkg::OFS_CONTROL, 8'h10);
        wr(psp_pkg::OFS_PORT_E_DIR, 8'hFF);
        $display("test refused strobes done");
        print_verdict();
    end
endmodule
